// File: asd_decoder.sv
// Purpose: route core accesses to RAM, control, flash or ROM targets
// Assumes: targets answer read data in the same cycle as the strobe
// Notes: read data is muxed one cycle after the request
`timescale 1ns/1ps
module asd_decoder #(
  parameter int RAM_BYTES   = 4096,
  parameter int FLASH_BYTES = 65536,
  parameter logic [8*20-1:0] PART_ID = {"ASD-PART-0", {10{8'h00}}} // arbitrary
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // core request
  input  wire asd_pkg::asd_req_type req,
  input  wire logic               load_external_data,
  input  wire logic               load_external_data_incr,
  // core answer
  output logic                    rvalid,
  output logic [7:0]              rdata,
  output asd_pkg::asd_pslot_type  pslot,
  output logic                    watchdog_vector_source,
  // ram port
  output logic                    ram_en,
  output logic                    ram_we,
  output logic [11:0]             ram_addr,
  output logic [7:0]              ram_wdata,
  input  wire logic [7:0]         ram_rdata,
  // control register port
  output logic                    ctl_en,
  output logic                    ctl_we,
  output logic [7:0]              ctl_addr,
  output logic [7:0]              ctl_wdata,
  input  wire logic [7:0]         ctl_rdata,
  // flash port
  output logic                    fl_en,
  output logic                    fl_we,
  output logic [15:0]             fl_addr,
  output logic [7:0]              fl_wdata,
  input  wire logic [7:0]         fl_rdata
);
  // derived boundaries
  localparam logic [12:0] RAM_TOP =
    13'(RAM_BYTES > int'(asd_pkg::CTL_BASE) ?
        int'(asd_pkg::CTL_BASE) : RAM_BYTES);
  localparam logic [16:0] FL_TOP = 17'(FLASH_BYTES);

  typedef struct packed {
    logic                   pend;
    logic                   rvalid;
    logic [7:0]             rdata;
    asd_pkg::asd_pslot_type pslot;
    logic                   wdog;
    asd_pkg::asd_target_type tgt;
    logic [4:0]             pn_idx;
    logic                   ram_en;
    logic                   ram_we;
    logic [11:0]            ram_addr;
    logic [7:0]             ram_wdata;
    logic                   ctl_en;
    logic                   ctl_we;
    logic [7:0]             ctl_addr;
    logic [7:0]             ctl_wdata;
    logic                   fl_en;
    logic                   fl_we;
    logic [15:0]            fl_addr;
    logic [7:0]             fl_wdata;
  } asd_state_type;

  asd_state_type st;
  asd_state_type next_st;

  function automatic logic [7:0] pn_byte(input logic [4:0] i);
    pn_byte = asd_pkg::ZERO_BYTE;
    if (int'(i) < asd_pkg::PN_LEN) begin
      pn_byte = PART_ID[8*(asd_pkg::PN_LEN-1-int'(i)) +: 8];
    end
  endfunction

  // offset inside the control window
  function automatic logic [7:0] ctl_off(
    input logic [11:0] a
  );
    ctl_off = 8'(a - asd_pkg::CTL_BASE);
  endfunction

  // register file control window
  function automatic logic in_ctl(
    input logic [11:0] a
  );
    in_ctl = (a >= asd_pkg::CTL_BASE);
  endfunction

  // implemented ram below the control window
  function automatic logic in_ram(
    input logic [11:0] a
  );
    in_ram = ({1'b0, a} < RAM_TOP);
  endfunction

  // implemented flash at the low end
  function automatic logic in_flash(
    input logic [15:0] a
  );
    in_flash = ({1'b0, a} < FL_TOP);
  endfunction

  // read-only area at the data top
  function automatic logic in_rom(
    input logic [15:0] a
  );
    in_rom = (a >= asd_pkg::ROM_BASE);
  endfunction

  // part identifier string slots
  function automatic logic in_pn(
    input logic [15:0] a
  );
    in_pn = (a >= asd_pkg::PN_BASE) && (a <= asd_pkg::PN_LAST);
  endfunction

  // string position inside the identifier
  function automatic logic [4:0] pn_pos(
    input logic [15:0] a
  );
    pn_pos = asd_pkg::PN_NONE;
    if (in_pn(a)) begin
      pn_pos = 5'(a - asd_pkg::PN_BASE);
    end
  endfunction

  // program memory slot of an address
  function automatic asd_pkg::asd_pslot_type pm_slot(
    input logic [15:0] a
  );
    if (a < asd_pkg::RST_VEC) begin
      pm_slot = asd_pkg::PS_OPT;
    end else if (a < asd_pkg::IRQ_VEC_LO) begin
      pm_slot = asd_pkg::PS_VEC;
    end else if (a <= asd_pkg::IRQ_VEC_HI) begin
      pm_slot = asd_pkg::PS_IRQ;
    end else begin
      pm_slot = asd_pkg::PS_CODE;
    end
  endfunction

  // watchdog vector pair
  function automatic logic is_wdog(
    input logic [15:0] a
  );
    is_wdog = (a >= asd_pkg::WDOG_VEC) && (a < asd_pkg::TRAP_VEC);
  endfunction

  // read answer by the target of the request
  function automatic logic [7:0] answer(
    input asd_pkg::asd_target_type t,
    input logic [4:0]              idx,
    input logic [7:0]              rd_ram,
    input logic [7:0]              rd_ctl,
    input logic [7:0]              rd_fl
  );
    case (t)
      asd_pkg::TG_RAM: begin
        answer = rd_ram;
      end
      asd_pkg::TG_CTL: begin
        answer = rd_ctl;
      end
      asd_pkg::TG_FLSH: begin
        answer = rd_fl;
      end
      asd_pkg::TG_ROM: begin
        answer = pn_byte(idx);
      end
      asd_pkg::TG_NONE: begin
        answer = asd_pkg::BLANK_BYTE;
      end
      default: begin
        answer = asd_pkg::BLANK_BYTE;
      end
    endcase
  endfunction

  always_comb begin
    logic [11:0] ra;
    logic [15:0] pa;
    ra = req.addr[11:0];
    pa = req.addr;
    next_st = st;
    // strobes last one cycle
    next_st.ram_en = 1'b0;
    next_st.ram_we = 1'b0;
    next_st.ctl_en = 1'b0;
    next_st.ctl_we = 1'b0;
    next_st.fl_en = 1'b0;
    next_st.fl_we = 1'b0;

    // answer for the read strobed last cycle
    next_st.pend = 1'b0;
    next_st.rvalid = st.pend;
    if (st.pend) begin
      next_st.rdata = answer(st.tgt, st.pn_idx, ram_rdata, ctl_rdata,
                             fl_rdata);
    end

    // new request
    if (req.valid) begin
      next_st.pend = !req.write;
      next_st.tgt = asd_pkg::TG_NONE;
      case (req.space)
        asd_pkg::SP_RF: begin
          if (in_ctl(ra)) begin
            next_st.tgt = asd_pkg::TG_CTL;
            next_st.ctl_en = 1'b1;
            next_st.ctl_we = req.write;
            next_st.ctl_addr = ctl_off(ra);
            next_st.ctl_wdata = req.wdata;
          end else if (in_ram(ra)) begin
            next_st.tgt = asd_pkg::TG_RAM;
            next_st.ram_en = 1'b1;
            next_st.ram_we = req.write;
            next_st.ram_addr = ra - asd_pkg::RAM_BASE;
            next_st.ram_wdata = req.wdata;
          end else begin
            next_st.tgt = asd_pkg::TG_NONE;
          end
        end
        asd_pkg::SP_PM: begin
          if (in_flash(pa)) begin
            next_st.tgt = asd_pkg::TG_FLSH;
            next_st.fl_en = 1'b1;
            next_st.fl_we = req.write;
            next_st.fl_addr = pa;
            next_st.fl_wdata = req.wdata;
          end else begin
            next_st.tgt = asd_pkg::TG_NONE;
          end
          next_st.pslot = pm_slot(pa);
          next_st.wdog = is_wdog(pa);
        end
        asd_pkg::SP_DM: begin
          if (in_rom(pa) && !req.write &&
              (load_external_data || load_external_data_incr)) begin
            next_st.tgt = asd_pkg::TG_ROM;
            next_st.pn_idx = pn_pos(pa);
          end else begin
            next_st.tgt = asd_pkg::TG_NONE;
          end
        end
        default: begin
          next_st.tgt = asd_pkg::TG_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // answer side
      st.pend <= 1'b0;
      st.rvalid <= 1'b0;
      st.rdata <= asd_pkg::ZERO_BYTE;
      st.pslot <= asd_pkg::PS_OPT;
      st.wdog <= 1'b0;
      st.tgt <= asd_pkg::TG_NONE;
      st.pn_idx <= asd_pkg::PN_NONE;
      // target strobes
      st.ram_en <= 1'b0;
      st.ram_we <= 1'b0;
      st.ram_addr <= '0;
      st.ram_wdata <= '0;
      st.ctl_en <= 1'b0;
      st.ctl_we <= 1'b0;
      st.ctl_addr <= '0;
      st.ctl_wdata <= '0;
      st.fl_en <= 1'b0;
      st.fl_we <= 1'b0;
      st.fl_addr <= '0;
      st.fl_wdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  // core answer
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign pslot = st.pslot;
  assign watchdog_vector_source = st.wdog;
  // ram port
  assign ram_en = st.ram_en;
  assign ram_we = st.ram_we;
  assign ram_addr = st.ram_addr;
  assign ram_wdata = st.ram_wdata;
  // control port
  assign ctl_en = st.ctl_en;
  assign ctl_we = st.ctl_we;
  assign ctl_addr = st.ctl_addr;
  assign ctl_wdata = st.ctl_wdata;
  // flash port
  assign fl_en = st.fl_en;
  assign fl_we = st.fl_we;
  assign fl_addr = st.fl_addr;
  assign fl_wdata = st.fl_wdata;
endmodule

// File: asd_pkg.sv
// Purpose: constants and carriers for the address space decoder
// Assumes: byte-wide core accesses, one request per cycle
// Notes: ram and flash bounds derive from the size parameters
package asd_pkg;
  localparam int RF_AW = 12;
  localparam int PM_AW = 16;
  localparam int RF_SIZE = 4096;
  localparam int CTL_SIZE = 256;
  localparam logic [11:0] CTL_BASE = 12'hf00;
  localparam logic [11:0] RAM_BASE = 12'h000;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] OPT_BASE = 16'h0000;
  localparam logic [15:0] RST_VEC = 16'h0002;
  localparam logic [15:0] WDOG_VEC = 16'h0004;
  localparam logic [15:0] TRAP_VEC = 16'h0006;
  localparam logic [15:0] IRQ_VEC_LO = 16'h0008;
  localparam logic [15:0] IRQ_VEC_HI = 16'h0037;
  localparam logic [15:0] CODE_BASE = 16'h0038;
  localparam logic [15:0] ROM_BASE = 16'hff80;
  localparam logic [15:0] PN_BASE = 16'hffc0;
  localparam logic [15:0] PN_LAST = 16'hffd3;
  localparam int PN_LEN = 20;
  localparam logic [4:0] PN_NONE = 5'h1f;

  typedef enum logic [1:0] {
    SP_RF = 2'h0,
    SP_PM = 2'h1,
    SP_DM = 2'h2
  } asd_space_type;

  typedef enum logic [4:0] {
    TG_NONE = 5'h01,
    TG_RAM  = 5'h02,
    TG_CTL  = 5'h04,
    TG_FLSH = 5'h08,
    TG_ROM  = 5'h10
  } asd_target_type;

  typedef enum logic [3:0] {
    PS_OPT  = 4'h1,
    PS_VEC  = 4'h2,
    PS_IRQ  = 4'h4,
    PS_CODE = 4'h8
  } asd_pslot_type;

  typedef struct packed {
    logic          valid;
    logic          write;
    asd_space_type space;
    logic [15:0]   addr;
    logic [7:0]    wdata;
  } asd_req_type;
endpackage

// File: asd_target_model.sv
// Purpose: target side model for asd_decoder
// Assumes: read data valid while strobe high
// Notes: idle data changes every cycle
`timescale 1ns/1ps
module asd_target_model (
  // clock
  input  wire logic        core_clk,
  // strobes
  input  wire logic        ram_en,
  input  wire logic [11:0] ram_addr,
  input  wire logic        ctl_en,
  input  wire logic [7:0]  ctl_addr,
  input  wire logic        fl_en,
  input  wire logic [15:0] fl_addr,
  // read data
  output logic [7:0]       ram_rdata,
  output logic [7:0]       ctl_rdata,
  output logic [7:0]       fl_rdata
);
  logic [7:0] junk = 8'h00;
  always @(posedge core_clk) junk <= junk + 8'h01;
  assign ram_rdata = ram_en ? ram_addr[7:0] ^ 8'h5a : junk;
  assign ctl_rdata = ctl_en ? ctl_addr ^ 8'h5a : ~junk;
  assign fl_rdata = fl_en ? fl_addr[7:0] ^ 8'h5a : junk;
endmodule

// File: asd_decoder_monitor.sv
// Purpose: port checks for asd_decoder
// Assumes: default part identifier
// Notes: bound from the bench top
`timescale 1ns/1ps
module asd_decoder_monitor #(
  parameter int RAM_BYTES   = 4096,
  parameter int FLASH_BYTES = 65536
) (
  // watched ports
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire asd_pkg::asd_req_type req,
  input wire logic                 load_external_data,
  input wire logic                 load_external_data_incr,
  input wire logic                 rvalid,
  input wire logic [7:0]           rdata,
  input wire logic                 watchdog_vector_source,
  input wire logic                 ram_en,
  input wire logic [11:0]          ram_addr,
  input wire logic                 ctl_en,
  input wire logic [7:0]           ctl_addr,
  input wire logic                 fl_en
);
  wire rf = req.valid && req.space == asd_pkg::SP_RF;
  wire pm = req.valid && req.space == asd_pkg::SP_PM;
  wire dm = req.valid && req.space == asd_pkg::SP_DM && !req.write;
  wire ld = load_external_data || load_external_data_incr;
  wire [11:0] ra = req.addr[11:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ram_route: assert property (
    rf && ra < RAM_BYTES && ra < 12'hf00
    |=> ram_en && ram_addr == $past(ra))
    else $error("ram access not routed");
  chk_ctl_route: assert property (
    rf && ra[11:8] == 4'hf |=> ctl_en && ctl_addr == $past(ra[7:0]))
    else $error("control access not routed");
  chk_gap_quiet: assert property (
    rf && ra >= RAM_BYTES && ra < 12'hf00 |=> !ram_en && !ctl_en)
    else $error("gap access strobed");
  chk_flash_route: assert property (
    pm && req.addr < FLASH_BYTES |=> fl_en)
    else $error("flash access not routed");
  chk_pm_blank: assert property (
    pm && !req.write && req.addr >= FLASH_BYTES
    |=> !fl_en ##1 rvalid && rdata == 8'hff)
    else $error("blank program read wrong");
  chk_wdog_slot: assert property (
    pm && req.addr[15:1] == 15'h0002 |-> ##[1:2] watchdog_vector_source)
    else $error("watchdog slot not flagged");
  chk_part_id: assert property (
    dm && ld && req.addr == asd_pkg::PN_BASE
    |-> ##2 rvalid && rdata == 8'h41)
    else $error("part identifier wrong");
  chk_dm_plain: assert property (
    dm && !ld |-> ##2 rvalid && rdata == 8'hff)
    else $error("plain data read wrong");
endmodule

// File: tb_asd_decoder.sv
// Purpose: self-checking bench for asd_decoder
// Assumes: 2KB RAM, 16KB flash
// Notes: one access at a time
`timescale 1ns/1ps
module tb_asd_decoder;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  asd_pkg::asd_req_type req = '0;
  logic ld = 1'b0;
  logic ldi = 1'b0;
  logic rvalid, ram_en, ram_we, ctl_en, ctl_we, fl_en, fl_we, wdog;
  logic [7:0] rdata, ram_wdata, ctl_wdata, fl_wdata, ctl_addr;
  logic [7:0] ram_rdata, ctl_rdata, fl_rdata;
  logic [11:0] ram_addr;
  logic [15:0] fl_addr;
  asd_pkg::asd_pslot_type pslot;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial forever #2.5 core_clk = ~core_clk;
  asd_decoder #(.RAM_BYTES(2048), .FLASH_BYTES(16384)) u_asd_decoder (
    .core_clk(core_clk), .rst_n(rst_n), .req(req),
    .load_external_data(ld), .load_external_data_incr(ldi),
    .rvalid(rvalid), .rdata(rdata), .pslot(pslot),
    .watchdog_vector_source(wdog), .ram_en(ram_en), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .ctl_en(ctl_en), .ctl_we(ctl_we), .ctl_addr(ctl_addr),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .fl_en(fl_en),
    .fl_we(fl_we), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_rdata(fl_rdata));
  asd_target_model u_asd_target_model (
    .core_clk(core_clk), .ram_en(ram_en), .ram_addr(ram_addr),
    .ctl_en(ctl_en), .ctl_addr(ctl_addr), .fl_en(fl_en),
    .fl_addr(fl_addr), .ram_rdata(ram_rdata), .ctl_rdata(ctl_rdata),
    .fl_rdata(fl_rdata));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [1:0] sp,
    input logic [15:0] a, input logic [2:0] en, input logic [7:0] ex);
    @(posedge core_clk) #1;
    req = '{1'b1, w, asd_pkg::asd_space_type'(sp), a, a[7:0]};
    @(posedge core_clk) #1;
    req.valid = 1'b0;
    check({ram_en, ctl_en, fl_en}, en);
    check({ram_we, ctl_we, fl_we}, w ? en : 3'h0);
    if (en[2]) check({ram_addr, ram_wdata}, {a[11:0], a[7:0]});
    if (en[1]) check({ctl_addr, ctl_wdata}, {a[7:0], a[7:0]});
    if (en[0]) check({fl_addr, fl_wdata}, {a, a[7:0]});
    @(posedge core_clk) #1;
    check(rvalid, !w);
    if (!w) check(rdata, ex);
  endtask
  task automatic t_rf();
    acc(0, 0, 16'h0000, 3'h4, 8'h5a);
    acc(0, 0, 16'h07ff, 3'h4, 8'ha5);
    acc(0, 0, 16'h0800, 3'h0, 8'hff);
    acc(1, 0, 16'h0eff, 3'h0, 8'h00);
    acc(0, 0, 16'h0f00, 3'h2, 8'h5a);
    acc(0, 0, 16'h0fff, 3'h2, 8'ha5);
    acc(1, 0, 16'h0f06, 3'h2, 8'h00);
    acc(1, 0, 16'h0123, 3'h4, 8'h00);
  endtask
  task automatic t_pm();
    logic [15:0] ad [5] = '{16'h0, 16'h4, 16'h6, 16'h37, 16'h38};
    logic [3:0] sl [5] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h8};
    for (int i = 0; i < 5; i++) begin
      acc(0, 1, ad[i], 3'h1, ad[i][7:0] ^ 8'h5a);
      check(pslot, sl[i]);
      check(wdog, ad[i] == 16'h0004);
    end
    acc(0, 1, 16'h3fff, 3'h1, 8'ha5);
    acc(0, 1, 16'h4000, 3'h0, 8'hff);
    acc(1, 1, 16'hffff, 3'h0, 8'h00);
  endtask
  task automatic t_dm();
    ld = 1'b1;
    acc(0, 2, 16'hffc0, 3'h0, 8'h41);
    acc(0, 2, 16'hffc9, 3'h0, 8'h30);
    acc(0, 2, 16'hffd3, 3'h0, 8'h00);
    acc(0, 2, 16'hff80, 3'h0, 8'h00);
    acc(0, 2, 16'hff7f, 3'h0, 8'hff);
    acc(1, 2, 16'hffc0, 3'h0, 8'h00);
    ld = 1'b0;
    acc(0, 2, 16'hffc0, 3'h0, 8'hff);
    ldi = 1'b1;
    acc(0, 2, 16'hffc1, 3'h0, 8'h53);
    ldi = 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    check({rvalid, rdata, pslot, wdog}, 14'h0002);
    t_rf();
    t_pm();
    t_dm();
    results();
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 500) begin
      err_total++;
      results();
    end
  end
endmodule
bind asd_decoder asd_decoder_monitor #(
  .RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)
) u_asd_decoder_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .req(req),
  .load_external_data(load_external_data),
  .load_external_data_incr(load_external_data_incr),
  .rvalid(rvalid), .rdata(rdata),
  .watchdog_vector_source(watchdog_vector_source), .ram_en(ram_en),
  .ram_addr(ram_addr), .ctl_en(ctl_en), .ctl_addr(ctl_addr),
  .fl_en(fl_en));
